// ### src/idx_core.sv
// Instruction decode and execute core with a Wishbone register port
`timescale 1ns/100ps
`default_nettype none
module idx_core #(
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // Wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [9:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output wire logic [31:0] WB_DAT_OUT,
    output wire logic WB_ACK_OUT,
    // I/O port pins and latch
    input wire logic [7:0] PORT_PINS_IN,
    output wire logic [7:0] PORT_LATCH_OUT,
    // Side effects towards timer and watchdog, and the standby flag
    output wire logic PRESCALE_CLEAR_OUT,
    output wire logic WDOG_CLEAR_OUT,
    output wire logic STANDBY_OUT
);
    localparam int SPW = $clog2(STACK_DEPTH);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        idx_pkg::idx_seq_t seq;
        logic [1:0] div;
        logic [13:0] ir;
        logic [12:0] pc;
        logic [STACK_DEPTH-1:0][12:0] stack;
        logic [SPW-1:0] sp;
        logic [7:0] acc;
        logic [127:0][7:0] file;
        logic c;
        logic hcar;
        logic z;
        logic slp;
        logic expd;
        logic presc_t0;
        logic standby;
        logic presc_clr;
        logic wdt_clr;
        logic [7:0] pin_s1;
        logic [7:0] pin_s2;
        logic ack;
        logic [31:0] dat;
    } idx_state_t;

    idx_state_t s_q;
    idx_state_t s_d;

    // Adder giving {carry, half carry, sum}; subtraction feeds ~b and carry in
    function automatic logic [9:0] idx_add8(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        idx_add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction : idx_add8

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    logic tick;
    logic go;
    logic [6:0] fa;
    logic dst;
    logic [2:0] bsel;
    logic [7:0] fval;
    logic [7:0] lit;
    logic [9:0] sum;
    logic [7:0] res;
    logic wr_w;
    logic wr_f;
    logic upd_z;
    logic upd_cdc;
    logic c_new;
    logic hcar_new;
    logic skip;
    logic two;
    logic push;
    logic pop;
    logic set_wdt;
    logic set_sleep;
    logic [12:0] pc_inc;
    logic [12:0] pc_br;
    logic bus_req;

    // Instruction cycle boundary every four clocks
    assign tick = (s_q.div == idx_pkg::DIV_LAST);
    assign go = tick && (s_q.seq == idx_pkg::SQ_PEND);
    assign bus_req = WB_CYC_IN && WB_STB_IN && !s_q.ack;
    assign pc_inc = 13'(s_q.pc + 13'h0001);

    // Operand fetch and per-opcode result, flags and flow
    always_comb begin
        fa = s_q.ir[6:0];
        dst = s_q.ir[7];
        bsel = s_q.ir[9:7];
        lit = s_q.ir[7:0];
        // Port reads see the pins so read-modify-write cannot resurrect a low input
        fval = (fa == idx_pkg::PORT_ADDR) ? s_q.pin_s2 : s_q.file[fa];
        sum = 10'h000;
        res = 8'h00;
        wr_w = 1'b0;
        wr_f = 1'b0;
        upd_z = 1'b0;
        upd_cdc = 1'b0;
        c_new = s_q.c;
        hcar_new = s_q.hcar;
        skip = 1'b0;
        two = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        set_wdt = 1'b0;
        set_sleep = 1'b0;
        pc_br = pc_inc;
        case (s_q.ir[13:12])
            idx_pkg::PFX_BYTE: begin
                wr_w = !dst;
                wr_f = dst;
                upd_z = 1'b1;
                case (s_q.ir[11:8])
                    4'h0: begin
                        upd_z = 1'b0;
                        wr_w = 1'b0;
                        res = s_q.acc; // Store accumulator when d is set
                        if (s_q.ir == idx_pkg::W_RETURN || s_q.ir == idx_pkg::W_INT_RETURN) begin
                            pop = 1'b1;
                            two = 1'b1;
                            pc_br = s_q.stack[s_q.sp - SPW'(1)];
                        end else if (s_q.ir == idx_pkg::W_WDOG_CLEAR) begin
                            set_wdt = 1'b1;
                        end else if (s_q.ir == idx_pkg::W_STANDBY) begin
                            set_sleep = 1'b1;
                        end
                    end
                    4'h1: res = 8'h00; // Clear file or accumulator
                    4'h2: begin
                        sum = idx_add8(fval, ~s_q.acc, 1'b1);
                        res = sum[7:0];
                        upd_cdc = 1'b1;
                    end
                    4'h3: res = 8'(fval - 8'h01);
                    4'h4: res = s_q.acc | fval;
                    4'h5: res = s_q.acc & fval;
                    4'h6: res = s_q.acc ^ fval;
                    4'h7: begin
                        sum = idx_add8(s_q.acc, fval, 1'b0);
                        res = sum[7:0];
                        upd_cdc = 1'b1;
                    end
                    4'h8: res = fval;
                    4'h9: res = ~fval;
                    4'ha: res = 8'(fval + 8'h01);
                    4'hb: begin
                        res = 8'(fval - 8'h01);
                        upd_z = 1'b0;
                        skip = (res == 8'h00);
                    end
                    4'hc: begin
                        res = {s_q.c, fval[7:1]};
                        c_new = fval[0];
                        upd_z = 1'b0;
                    end
                    4'hd: begin
                        res = {fval[6:0], s_q.c};
                        c_new = fval[7];
                        upd_z = 1'b0;
                    end
                    4'he: begin
                        res = {fval[3:0], fval[7:4]};
                        upd_z = 1'b0;
                    end
                    default: begin
                        res = 8'(fval + 8'h01);
                        upd_z = 1'b0;
                        skip = (res == 8'h00);
                    end
                endcase
                if (s_q.ir[11:8] == 4'h1) begin
                    upd_z = 1'b1;
                end
            end
            idx_pkg::PFX_BIT: begin
                res = fval;
                case (s_q.ir[11:10])
                    2'h0: begin
                        res[bsel] = 1'b0;
                        wr_f = 1'b1;
                    end
                    2'h1: begin
                        res[bsel] = 1'b1;
                        wr_f = 1'b1;
                    end
                    2'h2: skip = !fval[bsel];
                    default: skip = fval[bsel];
                endcase
            end
            idx_pkg::PFX_BRANCH: begin
                two = 1'b1;
                push = !s_q.ir[11];
                pc_br = {s_q.pc[12:11], s_q.ir[10:0]};
            end
            default: begin
                wr_w = 1'b1;
                upd_z = 1'b1;
                case (s_q.ir[11:9])
                    3'h0, 3'h1: upd_z = 1'b0; // Move literal, no flags
                    3'h2, 3'h3: begin
                        upd_z = 1'b0;
                        pop = 1'b1;
                        two = 1'b1;
                        pc_br = s_q.stack[s_q.sp - SPW'(1)];
                    end
                    3'h4: begin
                        case (s_q.ir[8])
                            1'b0: res = s_q.acc | lit;
                            default: res = s_q.acc & lit;
                        endcase
                    end
                    3'h5: res = s_q.acc ^ lit;
                    3'h6: begin
                        sum = idx_add8(lit, ~s_q.acc, 1'b1);
                        res = sum[7:0];
                        upd_cdc = 1'b1;
                    end
                    default: begin
                        sum = idx_add8(s_q.acc, lit, 1'b0);
                        res = sum[7:0];
                        upd_cdc = 1'b1;
                    end
                endcase
                if (s_q.ir[11:9] <= 3'h3) begin
                    res = lit;
                end
            end
        endcase
        if (upd_cdc) begin
            c_new = sum[9];
            hcar_new = sum[8];
        end
        // A true skip steps over one word and costs a dead cycle
        if (skip) begin
            two = 1'b1;
            pc_br = 13'(s_q.pc + 13'h0002);
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.div = 2'(s_q.div + 2'h1);
        s_d.pin_s1 = PORT_PINS_IN;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.ack = bus_req;
        s_d.presc_clr = 1'b0;
        s_d.wdt_clr = 1'b0;
        // Sequencer: pending word runs at a boundary, branches add a dead cycle
        case (s_q.seq)
            idx_pkg::SQ_PEND: begin
                if (tick) begin
                    s_d.seq = two ? idx_pkg::SQ_NOP : idx_pkg::SQ_IDLE;
                end
            end
            idx_pkg::SQ_NOP: begin
                if (tick) begin
                    s_d.seq = idx_pkg::SQ_IDLE;
                end
            end
            default: s_d.seq = idx_pkg::SQ_IDLE;
        endcase
        // Execute effects
        if (go) begin
            s_d.pc = pc_br;
            if (wr_w) begin
                s_d.acc = res;
            end
            if (wr_f) begin
                s_d.file[fa] = res;
                // Timer count write restarts its prescaler
                if (fa == idx_pkg::TIMER_ZERO_ADDR && s_q.presc_t0) begin
                    s_d.presc_clr = 1'b1;
                end
            end
            if (upd_z) begin
                s_d.z = (res == 8'h00);
            end
            s_d.c = c_new;
            s_d.hcar = hcar_new;
            if (push) begin
                s_d.stack[s_q.sp] = pc_inc;
                s_d.sp = SPW'(s_q.sp + SPW'(1));
            end
            if (pop) begin
                s_d.sp = SPW'(s_q.sp - SPW'(1));
            end
            if (set_wdt || set_sleep) begin
                s_d.expd = 1'b1;
                s_d.slp = set_wdt;
                s_d.wdt_clr = set_wdt;
                s_d.standby = set_sleep;
            end
        end
        // Bus reads return the stored latch of a file word, not the pins
        s_d.dat = 32'h0000_0000;
        if (bus_req && !WB_WE_IN) begin
            if (WB_ADR_IN[idx_pkg::ADR_FILE_BIT]) begin
                s_d.dat[7:0] = s_q.file[WB_ADR_IN[8:2]];
            end else begin
                case (WB_ADR_IN)
                    idx_pkg::ADR_INSTR: s_d.dat[13:0] = s_q.ir;
                    idx_pkg::ADR_ACCUM: s_d.dat[7:0] = s_q.acc;
                    idx_pkg::ADR_PC: s_d.dat[12:0] = s_q.pc;
                    idx_pkg::ADR_CTRL: s_d.dat[idx_pkg::CTRL_PRESC_T0] = s_q.presc_t0;
                    idx_pkg::ADR_STATUS: begin
                        s_d.dat[idx_pkg::ST_CARRY] = s_q.c;
                        s_d.dat[idx_pkg::ST_HALF] = s_q.hcar;
                        s_d.dat[idx_pkg::ST_ZERO] = s_q.z;
                        s_d.dat[idx_pkg::ST_SLEEP] = s_q.slp;
                        s_d.dat[idx_pkg::ST_EXPIRY] = s_q.expd;
                        s_d.dat[idx_pkg::ST_BUSY] = (s_q.seq != idx_pkg::SQ_IDLE);
                        s_d.dat[idx_pkg::ST_STANDBY] = s_q.standby;
                    end
                    default: s_d.dat = 32'h0000_0000;
                endcase
            end
        end
        // Writes other than control are ignored while an instruction is in flight
        if (bus_req && WB_WE_IN) begin
            if (WB_ADR_IN == idx_pkg::ADR_CTRL && WB_SEL_IN[0]) begin
                s_d.presc_t0 = WB_DAT_IN[idx_pkg::CTRL_PRESC_T0];
            end
            if (s_q.seq == idx_pkg::SQ_IDLE) begin
                if (WB_ADR_IN[idx_pkg::ADR_FILE_BIT]) begin
                    if (WB_SEL_IN[0]) begin
                        s_d.file[WB_ADR_IN[8:2]] = WB_DAT_IN[7:0];
                    end
                end else begin
                    case (WB_ADR_IN)
                        idx_pkg::ADR_INSTR: begin
                            if (WB_SEL_IN[1:0] == 2'h3) begin
                                s_d.ir = WB_DAT_IN[13:0];
                                s_d.seq = idx_pkg::SQ_PEND;
                                s_d.standby = 1'b0;
                            end
                        end
                        idx_pkg::ADR_ACCUM: begin
                            if (WB_SEL_IN[0]) begin
                                s_d.acc = WB_DAT_IN[7:0];
                            end
                        end
                        idx_pkg::ADR_PC: begin
                            if (WB_SEL_IN[1:0] == 2'h3) begin
                                s_d.pc = WB_DAT_IN[12:0];
                            end
                        end
                        idx_pkg::ADR_STATUS: begin
                            if (WB_SEL_IN[0]) begin
                                s_d.c = WB_DAT_IN[idx_pkg::ST_CARRY];
                                s_d.hcar = WB_DAT_IN[idx_pkg::ST_HALF];
                                s_d.z = WB_DAT_IN[idx_pkg::ST_ZERO];
                            end
                        end
                        default: s_d.acc = s_q.acc;
                    endcase
                end
            end
        end
    end

    // Synchronous reset of the whole state word
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            s_q <= '0;
            s_q.seq <= idx_pkg::SQ_IDLE;
            s_q.expd <= idx_pkg::RST_EXPIRY;
            s_q.slp <= idx_pkg::RST_SLEEP;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state word
    assign WB_DAT_OUT = s_q.dat;
    assign WB_ACK_OUT = s_q.ack;
    assign PORT_LATCH_OUT = s_q.file[idx_pkg::PORT_ADDR];
    assign PRESCALE_CLEAR_OUT = s_q.presc_clr;
    assign WDOG_CLEAR_OUT = s_q.wdt_clr;
    assign STANDBY_OUT = s_q.standby;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    property p_cycle_len;
        tick |=> !tick [*3] ##1 tick;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");

    property p_two_cycle;
        (go && two) |=> (s_q.seq == idx_pkg::SQ_NOP) [*4] ##1 (s_q.seq == idx_pkg::SQ_IDLE);
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("dead cycle missing");

    property p_presc;
        (go && wr_f && fa == idx_pkg::TIMER_ZERO_ADDR && s_q.presc_t0) |=> PRESCALE_CLEAR_OUT;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not cleared");

    property p_standby;
        (go && s_q.ir == idx_pkg::W_STANDBY) |=> STANDBY_OUT && s_q.expd && !s_q.slp
            && s_q.seq == idx_pkg::SQ_IDLE;
    endproperty
    a_standby: assert property (p_standby) else $error("standby flags wrong");

    property p_decskip;
        (go && s_q.ir[13:8] == 6'h0b && fval == 8'h01) |=> s_q.pc == 13'($past(s_q.pc) + 13'h0002);
    endproperty
    a_decskip: assert property (p_decskip) else $error("decrement skip failed");

    property p_and_flags;
        (go && s_q.ir[13:8] == 6'h05) |=> s_q.c == $past(s_q.c) && s_q.hcar == $past(s_q.hcar);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and changed carry");

    property p_call;
        (go && s_q.ir[13:11] == 3'h4) |=> s_q.pc[10:0] == $past(s_q.ir[10:0])
            && s_q.stack[$past(s_q.sp)] == $past(pc_inc);
    endproperty
    a_call: assert property (p_call) else $error("call target wrong");

    property p_return_with_literal;
        (go && s_q.ir[13:10] == 4'hd) |=> s_q.acc == $past(s_q.ir[7:0])
            && s_q.seq == idx_pkg::SQ_NOP;
    endproperty
    a_return_with_literal: assert property (p_return_with_literal) else $error("literal return wrong");

    property p_port_rmw;
        (go && fa == idx_pkg::PORT_ADDR && s_q.ir[13:8] == 6'h08 && dst)
            |=> PORT_LATCH_OUT == $past(s_q.pin_s2);
    endproperty
    a_port_rmw: assert property (p_port_rmw) else $error("port used latch");

endmodule : idx_core
`default_nettype wire

// ### src/idx_pkg.sv
// Constants and types shared by the instruction decode and execute block
`default_nettype none
package idx_pkg;
    // ---------------------------------------------------------------
    // Register map (byte addresses on the Wishbone bus)
    // ---------------------------------------------------------------
    localparam logic [9:0] ADR_INSTR = 10'h000;
    localparam logic [9:0] ADR_ACCUM = 10'h004;
    localparam logic [9:0] ADR_STATUS = 10'h008;
    localparam logic [9:0] ADR_PC = 10'h00c;
    localparam logic [9:0] ADR_CTRL = 10'h010;
    localparam int ADR_FILE_BIT = 9; // Set for the file window 0x200..0x3fc
    // ---------------------------------------------------------------
    // Status and control field positions
    // ---------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_EXPIRY = 4;
    localparam int ST_BUSY = 8;
    localparam int ST_STANDBY = 9;
    localparam int CTRL_PRESC_T0 = 0;
    // ---------------------------------------------------------------
    // Reset values and special file addresses
    // ---------------------------------------------------------------
    localparam logic RST_EXPIRY = 1'b1;
    localparam logic RST_SLEEP = 1'b1;
    localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
    localparam logic [6:0] PORT_ADDR = 7'h06;
    // ---------------------------------------------------------------
    // Fixed words and opcode fields
    // ---------------------------------------------------------------
    localparam logic [13:0] W_RETURN = 14'h0008;
    localparam logic [13:0] W_INT_RETURN = 14'h0009;
    localparam logic [13:0] W_STANDBY = 14'h0063;
    localparam logic [13:0] W_WDOG_CLEAR = 14'h0064;
    localparam logic [1:0] PFX_BYTE = 2'h0;
    localparam logic [1:0] PFX_BIT = 2'h1;
    localparam logic [1:0] PFX_BRANCH = 2'h2;
    localparam logic [1:0] PFX_LIT = 2'h3;
    // Instruction cycle length in oscillator periods
    localparam int OSC_PER_CYCLE = 4;
    localparam logic [1:0] DIV_LAST = 2'(OSC_PER_CYCLE - 1);
    // ---------------------------------------------------------------
    // Sequencer states, one-hot
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SQ_IDLE = 3'b001,
        SQ_PEND = 3'b010,
        SQ_NOP = 3'b100
    } idx_seq_t;
endpackage : idx_pkg
`default_nettype wire

// ### tb/idx_prog_mem.sv
// Program memory model holding the instruction words that the bench executes
`timescale 1ns/100ps
`default_nettype none
module idx_prog_mem (
    // Word select and word out
    input wire logic [4:0] addr_in,
    output logic [13:0] word_out
);
    logic [13:0] rom [0:26];
    // Fixed program: literal, byte, bit, branch and special words in turn
    initial begin
        rom = '{14'h3e05, 14'h00a0, 14'h3efb, 14'h0720, 14'h3c03, 14'h39f0, 14'h3af0,
            14'h380f, 14'h0da0, 14'h1820, 14'h1c20, 14'h1420, 14'h1c20, 14'h1020,
            14'h0620, 14'h05a0, 14'h0fa0, 14'h0ba0, 14'h04a0, 14'h0ca0, 14'h2010,
            14'h3455, 14'h2805, 14'h0063, 14'h0064, 14'h0081, 14'h0886};
    end
    assign word_out = rom[addr_in];
endmodule : idx_prog_mem
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench: runs a program through the Wishbone port
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, seen = 1'b0;
    logic [9:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, q, rdat;
    logic [7:0] pins = 8'ha5, latch;
    logic ack, presc, stby, wdog, seen_wd = 1'b0;
    logic [4:0] idx = '0;
    logic [13:0] word;
    int error_cnt = 0, n_tests = 0;
    logic [7:0] eacc [0:26] = '{8'h05, 8'h05, 8'h00, 8'h05, 8'hfe, 8'hf0, 8'h00, 8'h0f,
        8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05,
        8'h05, 8'h05, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55};
    logic [4:0] est [0:26] = '{5'h18, 5'h18, 5'h1f, 5'h18, 5'h18, 5'h18, 5'h1c, 5'h18,
        5'h18, 5'h18, 5'h18, 5'h18, 5'h18, 5'h18, 5'h18, 5'h1c, 5'h1c, 5'h1c, 5'h18,
        5'h19, 5'h19, 5'h19, 5'h19, 5'h11, 5'h19, 5'h19, 5'h19};
    logic [12:0] epc [0:26] = '{13'h01, 13'h02, 13'h03, 13'h04, 13'h05, 13'h06, 13'h07,
        13'h08, 13'h09, 13'h0b, 13'h0c, 13'h0d, 13'h0f, 13'h10, 13'h11, 13'h12, 13'h13,
        13'h15, 13'h16, 13'h17, 13'h10, 13'h18, 13'h05, 13'h06, 13'h07, 13'h08, 13'h09};
    idx_core dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PORT_PINS_IN(pins),
        .PORT_LATCH_OUT(latch), .PRESCALE_CLEAR_OUT(presc), .WDOG_CLEAR_OUT(wdog),
        .STANDBY_OUT(stby));
    idx_prog_mem mem (.addr_in(idx), .word_out(word));
    // Clock and sticky catches of the one-cycle prescaler and watchdog pulses
    initial forever #25 clk = ~clk;
    always @(posedge clk) if (presc === 1'b1) seen <= 1'b1;
    always @(posedge clk) if (wdog === 1'b1) seen_wd <= 1'b1;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Classic single cycle; held until ack is sampled, then released
    // No local limit: only the watchdog ends a wait for ack
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task test_done;
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // Watchdog: the program needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        int n;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, idx_pkg::ADR_STATUS, 32'h0);
        chk(q[4:0], 5'h18);
        wb(1'b0, 10'h020, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, idx_pkg::ADR_CTRL, 32'h1);
        for (int i = 0; i < 27; i++) begin
            idx = 5'(i);
            @(posedge clk);
            wb(1'b1, idx_pkg::ADR_INSTR, {18'h0, word});
            n = 0;
            do begin
                wb(1'b0, idx_pkg::ADR_STATUS, 32'h0);
                n++;
            end while (q[idx_pkg::ST_BUSY] !== 1'b0 && n < 20);
            chk(q[idx_pkg::ST_BUSY], 1'b0);
            chk(q[4:0], est[i]);
            if (i == 23) chk(stby, 1'b1);
            if (i == 23) chk(seen_wd, 1'b0);
            if (i == 24) chk(stby, 1'b0);
            if (i == 24) chk(seen, 1'b0);
            wb(1'b0, idx_pkg::ADR_ACCUM, 32'h0);
            chk(q[7:0], eacc[i]);
            wb(1'b0, idx_pkg::ADR_PC, 32'h0);
            chk(q[12:0], epc[i]);
        end
        chk(seen, 1'b1);
        chk(seen_wd, 1'b1);
        chk(latch, 8'ha5);
        wb(1'b0, 10'h280, 32'h0);
        chk(q[7:0], 8'h02);
        test_done;
    end
endmodule : tb
`default_nettype wire
